/* pkg/mscp_pkg.sv */
// package: register map, field positions, reset values and types for the serial port
package mscp_pkg;

  // register indices (word offsets chosen for this block)
  localparam logic [3:0] MSCP_REG_PIN_CTRL = 4'h0;
  localparam logic [3:0] MSCP_REG_RATE_TWO = 4'h1;
  localparam logic [3:0] MSCP_REG_RX_MCTL = 4'h2;
  localparam logic [3:0] MSCP_REG_TX_MCTL = 4'h3;
  localparam logic [3:0] MSCP_REG_FRAME = 4'h4;
  localparam logic [3:0] MSCP_REG_STATUS = 4'h5;
  localparam logic [3:0] MSCP_REG_CH_BASE = 4'h6; // spare control index
  localparam logic [3:0] MSCP_REG_CH_LAST = 4'hf;
  // channel enable registers sit at indices 16..27, rx first then tx
  localparam int MSCP_CH_REGS = 12;
  localparam int MSCP_CH_PER_DIR = 6;

  // pin control field positions
  localparam int PC_TX_GPIO = 13;
  localparam int PC_RX_GPIO = 12;
  localparam int PC_TX_FRAME_DIR = 11;
  localparam int PC_RX_FRAME_DIR = 10;
  localparam int PC_TX_CLK_DIR = 9;
  localparam int PC_RX_CLK_DIR = 8;
  localparam int PC_RATE_EXT_SEL = 7;
  localparam int PC_RATE_PIN_STATE = 6;
  localparam int PC_TX_DATA_STATE = 5;
  localparam int PC_RX_DATA_STATE = 4;
  localparam int PC_TX_FRAME_POL = 3;
  localparam int PC_RX_FRAME_POL = 2;
  localparam int PC_TX_CLK_POL = 1;
  localparam int PC_RX_CLK_POL = 0;
  localparam logic [15:0] PC_WRITE_MASK = 16'h3fff;

  // rate generator register two and multichannel control fields
  localparam int RG_SRC_SEL = 13;
  localparam int RG_DIV_LSB = 0;
  localparam int MC_WIDE_EN = 9;
  localparam int MC_MODE_EN = 0;
  // frame register: word length code [2:0], clock stop [4], spi master [5]
  localparam int FR_WLEN_LSB = 0;
  localparam int FR_CLK_STOP = 4;
  localparam int FR_SPI_MASTER = 5;

  localparam logic [15:0] MSCP_PC_RESET = 16'h0000;
  localparam logic [15:0] MSCP_RG_RESET = 16'h2001;
  localparam logic [15:0] MSCP_MC_RESET = 16'h0000;
  localparam logic [15:0] MSCP_FR_RESET = 16'h0002;
  localparam logic [15:0] MSCP_CH_RESET = 16'h0000;

  localparam int MSCP_LEGACY_CH = 32;
  localparam int MSCP_WIDE_CH = 128;

  typedef enum logic [1:0] {
    MSCP_SRC_RESERVED,
    MSCP_SRC_CPU,
    MSCP_SRC_RX_PIN,
    MSCP_SRC_TX_PIN
  } mscp_src_t;

  typedef struct packed {
    logic clk;
    logic frame;
    logic data;
  } mscp_pins_t;

  typedef struct packed {
    logic clk_oe;
    logic clk_out;
    logic frame_oe;
    logic frame_out;
  } mscp_drive_t;

endpackage

/* design/mscp_port.sv */
// serial port clocking, pin control and channel selection logic
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - with the wide enable clear a direction uses legacy 32-channel select, the reset default.
// - with the wide enable set a direction selects among channels 0..95; channels 96..127 are always on.
// - the wide enable of each direction is bit 9 of its multichannel control register.
// - in wide mode twelve channel-enable registers, rx and tx, pick active channels.
// - clock-stop mode runs only single-phase frames of one word.
// - the word length is 8, 12, 16, 20, 24 or 32 bits.
// - in spi mode transmitter and receiver are both master or both slave.
// - the rate clock source is picked from register-two bit 13 and the extended select bit.
// - extended select 0 with source 1 gives the cpu clock; source 0 is reserved.
// - extended select 1 takes the rx clock pin for source 0, tx clock pin for 1.
// - the clock pin used as rate input has its driver disabled always.
// - outside clock-stop mode, both clock directions at 1 clock tx and rx from the rate generator.
// - with the rx pin as rate input the generator drives only the tx clock pin.
// - logic is static and keeps state at any low serial clock rate.
// - multichannel frames are tdm streams with channels enabled per direction.
module mscp_port
  import mscp_pkg::*;
(
  input wire logic clock, // 125 mhz system clock
  input wire logic reset, // synchronous, active high
  input wire logic [4:0] addr, // register index
  input wire logic [15:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  output logic [15:0] rd_data, // read data, cycle after strobe
  input wire mscp_pins_t tx_pins_in, // tx clock, frame, data pin levels
  input wire mscp_pins_t rx_pins_in, // rx clock, frame, data pin levels
  output mscp_drive_t tx_drive, // tx clock and frame drivers
  output mscp_drive_t rx_drive, // rx clock and frame drivers
  output logic tx_data_out, // tx data pin level
  output logic tx_data_oe, // tx data pin enable
  output logic tx_chan_active, // current tx channel enabled
  output logic rx_chan_active, // current rx channel enabled
  output logic [6:0] tx_chan_idx, // current tx channel
  output logic [6:0] rx_chan_idx, // current rx channel
  output logic [5:0] word_bits, // serial word length in bits
  output logic rate_clock_tick, // rate generator output edge
  output logic cfg_error // illegal configuration flag
);

  // map the word length code onto bit count, illegal codes give 0
  function automatic logic [5:0] wlen_bits(input logic [2:0] code);
    unique case (code)
      3'h0: wlen_bits = 6'h08;
      3'h1: wlen_bits = 6'h0c;
      3'h2: wlen_bits = 6'h10;
      3'h3: wlen_bits = 6'h14;
      3'h4: wlen_bits = 6'h18;
      3'h5: wlen_bits = 6'h20;
      default: wlen_bits = 6'h00;
    endcase
  endfunction

  // channel enable lookup across six 16-bit registers (legacy uses two)
  function automatic logic chan_on(input logic [95:0] regs,
                                   input logic [6:0] ch,
                                   input logic wide);
    if (!wide && ch >= 7'(MSCP_LEGACY_CH))
      chan_on = 1'b0;
    else
      chan_on = (ch < 7'd96) ? regs[ch] : 1'b1;
  endfunction

  logic [15:0] pin_ctrl_r;
  logic [15:0] rate_two_r;
  logic [15:0] rx_mctl_r;
  logic [15:0] tx_mctl_r;
  logic [15:0] frame_r;
  logic [15:0] ch_en_r [MSCP_CH_REGS];
  logic [15:0] rd_data_r;
  logic [5:0] sync_r;
  logic [5:0] sync2_r;
  logic rx_clk_d_r, tx_clk_d_r;
  logic [7:0] div_cnt_r;
  logic rate_clk_r, rate_tick_r;
  logic [6:0] tx_ch_r, rx_ch_r;
  logic [4:0] tx_bit_r, rx_bit_r;
  logic tx_active_r, rx_active_r;

  // two-stage synchronisers for all six pins
  logic [5:0] pin_raw;
  logic [5:0] pin_s;
  assign pin_raw = {tx_pins_in, rx_pins_in};
  // only the second stage is read; the first may still be settling
  always_ff @(posedge clock) begin
    sync_r <= pin_raw;
    sync2_r <= sync_r;
  end
  assign pin_s = sync2_r;
  logic tx_clk_s, tx_frm_s, rx_clk_s, rx_frm_s, rx_dat_s;
  assign tx_clk_s = pin_s[5];
  assign tx_frm_s = pin_s[4];
  assign rx_clk_s = pin_s[2];
  assign rx_frm_s = pin_s[1];
  assign rx_dat_s = pin_s[0];

  // rate clock source selection
  mscp_src_t src;
  always_comb begin
    unique case ({pin_ctrl_r[PC_RATE_EXT_SEL], rate_two_r[RG_SRC_SEL]})
      2'b00: src = MSCP_SRC_RESERVED;
      2'b01: src = MSCP_SRC_CPU;
      2'b10: src = MSCP_SRC_RX_PIN;
      2'b11: src = MSCP_SRC_TX_PIN;
    endcase
  end

  // pin edge detection from synchronised levels only
  always_ff @(posedge clock) begin
    rx_clk_d_r <= rx_clk_s;
    tx_clk_d_r <= tx_clk_s;
  end
  logic src_edge;
  always_comb begin
    unique case (src)
      MSCP_SRC_CPU: src_edge = 1'b1;
      MSCP_SRC_RX_PIN: src_edge = rx_clk_s & ~rx_clk_d_r;
      MSCP_SRC_TX_PIN: src_edge = tx_clk_s & ~tx_clk_d_r;
      MSCP_SRC_RESERVED: src_edge = 1'b0; // no bonded pin, generator idles
    endcase
  end

  // rate divider; state is held when the source edges stop (static)
  always_ff @(posedge clock) begin
    if (reset) begin
      div_cnt_r <= 8'h00;
      rate_clk_r <= 1'b0;
      rate_tick_r <= 1'b0;
    end else begin
      rate_tick_r <= 1'b0;
      if (src_edge) begin
        if (div_cnt_r >= rate_two_r[RG_DIV_LSB +: 8]) begin
          div_cnt_r <= 8'h00;
          rate_clk_r <= ~rate_clk_r;
          rate_tick_r <= ~rate_clk_r;
        end else begin
          div_cnt_r <= div_cnt_r + 8'h01;
        end
      end
    end
  end

  // clock drivers: internal direction drives generator out, unless the pin
  // is the rate input, which can never drive (avoids a loop)
  logic tx_internal, rx_internal;
  logic spi_mode;
  assign spi_mode = frame_r[FR_CLK_STOP];
  // in spi mode both directions follow one master bit
  assign tx_internal = spi_mode ? frame_r[FR_SPI_MASTER]
                                : pin_ctrl_r[PC_TX_CLK_DIR];
  assign rx_internal = spi_mode ? frame_r[FR_SPI_MASTER]
                                : pin_ctrl_r[PC_RX_CLK_DIR];
  always_comb begin
    tx_drive.clk_oe = tx_internal && (src != MSCP_SRC_TX_PIN);
    rx_drive.clk_oe = rx_internal && (src != MSCP_SRC_RX_PIN);
    tx_drive.clk_out = rate_clk_r ^ pin_ctrl_r[PC_TX_CLK_POL];
    rx_drive.clk_out = rate_clk_r ^ pin_ctrl_r[PC_RX_CLK_POL];
    tx_drive.frame_oe = pin_ctrl_r[PC_TX_FRAME_DIR];
    rx_drive.frame_oe = pin_ctrl_r[PC_RX_FRAME_DIR];
    tx_drive.frame_out = pin_ctrl_r[PC_TX_FRAME_POL] ^ (tx_ch_r == 7'h00);
    rx_drive.frame_out = pin_ctrl_r[PC_RX_FRAME_POL] ^ (rx_ch_r == 7'h00);
  end
  assign tx_data_out = pin_ctrl_r[PC_TX_DATA_STATE];
  assign tx_data_oe = pin_ctrl_r[PC_TX_GPIO] | tx_active_r;
  assign rate_clock_tick = rate_tick_r;

  // bit clock per direction: internal means the generator, both set clocks
  // both from the generator; external means the sampled pin edge
  logic tx_bclk, rx_bclk;
  assign tx_bclk = tx_internal ? rate_tick_r
                               : (tx_clk_s & ~tx_clk_d_r);
  assign rx_bclk = rx_internal ? rate_tick_r
                               : (rx_clk_s & ~rx_clk_d_r);

  // word length, with clock-stop forcing one word per frame
  logic [5:0] wbits;
  logic [6:0] last_ch;
  assign wbits = wlen_bits(frame_r[FR_WLEN_LSB +: 3]);
  assign word_bits = wbits;
  assign last_ch = spi_mode ? 7'h00 : 7'h7f;

  // tdm channel counters; the frame pin, when set as input, restarts a frame at channel 0
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_ch_r <= 7'h00;
      tx_bit_r <= 5'h00;
    end else if (tx_frm_s && !pin_ctrl_r[PC_TX_FRAME_DIR]) begin
      tx_ch_r <= 7'h00;
      tx_bit_r <= 5'h00;
    end else if (tx_bclk && wbits != 6'h00) begin
      if (tx_bit_r == 5'(wbits - 6'h01)) begin
        tx_bit_r <= 5'h00;
        tx_ch_r <= (tx_ch_r == last_ch) ? 7'h00 : tx_ch_r + 7'h01;
      end else begin
        tx_bit_r <= tx_bit_r + 5'h01;
      end
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      rx_ch_r <= 7'h00;
      rx_bit_r <= 5'h00;
    end else if (rx_frm_s && !pin_ctrl_r[PC_RX_FRAME_DIR]) begin
      rx_ch_r <= 7'h00;
      rx_bit_r <= 5'h00;
    end else if (rx_bclk && wbits != 6'h00) begin
      if (rx_bit_r == 5'(wbits - 6'h01)) begin
        rx_bit_r <= 5'h00;
        rx_ch_r <= (rx_ch_r == last_ch) ? 7'h00 : rx_ch_r + 7'h01;
      end else begin
        rx_bit_r <= rx_bit_r + 5'h01;
      end
    end
  end
  assign tx_chan_idx = tx_ch_r;
  assign rx_chan_idx = rx_ch_r;

  // channel enable: multichannel off means every channel live
  logic [95:0] rx_bank, tx_bank;
  always_comb begin
    for (int i = 0; i < MSCP_CH_PER_DIR; i++) begin
      rx_bank[i*16 +: 16] = ch_en_r[i];
      tx_bank[i*16 +: 16] = ch_en_r[i + MSCP_CH_PER_DIR];
    end
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      tx_active_r <= 1'b0;
      rx_active_r <= 1'b0;
    end else begin
      tx_active_r <= !tx_mctl_r[MC_MODE_EN] ||
        chan_on(tx_bank, tx_ch_r, tx_mctl_r[MC_WIDE_EN]);
      rx_active_r <= !rx_mctl_r[MC_MODE_EN] ||
        chan_on(rx_bank, rx_ch_r, rx_mctl_r[MC_WIDE_EN]);
    end
  end
  assign tx_chan_active = tx_active_r;
  assign rx_chan_active = rx_active_r;
  assign cfg_error = (src == MSCP_SRC_RESERVED) || (wbits == 6'h00);

  // register writes; channel enable registers at indices 16..27
  always_ff @(posedge clock) begin
    if (reset) begin
      pin_ctrl_r <= MSCP_PC_RESET;
      rate_two_r <= MSCP_RG_RESET;
      rx_mctl_r <= MSCP_MC_RESET;
      tx_mctl_r <= MSCP_MC_RESET;
      frame_r <= MSCP_FR_RESET;
      for (int i = 0; i < MSCP_CH_REGS; i++)
        ch_en_r[i] <= MSCP_CH_RESET;
    end else if (wr_en) begin
      if (addr == {1'b0, MSCP_REG_PIN_CTRL})
        pin_ctrl_r <= wr_data & PC_WRITE_MASK;
      if (addr == {1'b0, MSCP_REG_RATE_TWO})
        rate_two_r <= wr_data;
      if (addr == {1'b0, MSCP_REG_RX_MCTL})
        rx_mctl_r <= wr_data;
      if (addr == {1'b0, MSCP_REG_TX_MCTL})
        tx_mctl_r <= wr_data;
      if (addr == {1'b0, MSCP_REG_FRAME})
        frame_r <= wr_data;
      if (addr[4] && addr[3:0] < 4'(MSCP_CH_REGS))
        ch_en_r[addr[3:0]] <= wr_data;
    end
  end

  // read mux; rx data state bit shows the live synchronised level, rate pin state bit reads 0
  logic [15:0] pc_view;
  always_comb begin
    pc_view = pin_ctrl_r;
    pc_view[PC_RATE_PIN_STATE] = 1'b0;
    pc_view[PC_RX_DATA_STATE] = rx_dat_s;
  end
  always_ff @(posedge clock) begin
    if (reset) begin
      rd_data_r <= 16'h0000;
    end else if (rd_en) begin
      if (addr[4])
        rd_data_r <= (addr[3:0] < 4'(MSCP_CH_REGS)) ? ch_en_r[addr[3:0]]
                                                     : 16'h0000;
      else begin
        unique case (addr[3:0])
          MSCP_REG_PIN_CTRL: rd_data_r <= pc_view;
          MSCP_REG_RATE_TWO: rd_data_r <= rate_two_r;
          MSCP_REG_RX_MCTL: rd_data_r <= rx_mctl_r;
          MSCP_REG_TX_MCTL: rd_data_r <= tx_mctl_r;
          MSCP_REG_FRAME: rd_data_r <= frame_r;
          MSCP_REG_STATUS: rd_data_r <= {8'h00, cfg_error, src, rx_frm_s,
                                         tx_frm_s, tx_active_r, rx_active_r,
                                         rate_clk_r};
          default: rd_data_r <= 16'h0000;
        endcase
      end
    end else begin
      rd_data_r <= 16'h0000;
    end
  end
  assign rd_data = rd_data_r;

endmodule
`default_nettype wire

/* tb/mscp_chk.sv */
// checker: concurrent assertions on the serial port top ports
`timescale 1ns/1ns
`default_nettype none
module mscp_chk
  import mscp_pkg::*;
(
  input wire logic clock, // system clock
  input wire logic reset, // synchronous reset
  input wire logic [4:0] addr, // register index
  input wire logic [15:0] wr_data, // write data
  input wire logic wr_en, // write strobe
  input wire logic rd_en, // read strobe
  input wire logic [15:0] rd_data, // read data
  input wire mscp_drive_t tx_drive, // tx drivers
  input wire mscp_drive_t rx_drive, // rx drivers
  input wire logic [5:0] word_bits, // word length
  input wire logic rate_clock_tick, // generator edge
  input wire logic cfg_error // bad setup flag
);
  logic [15:0] pc_r;
  logic [15:0] rg_r;
  logic [15:0] fr_r;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // shadows of the registers that steer the clock drivers
  always_ff @(posedge clock) begin
    if (reset) begin
      pc_r <= 16'h0000;
      rg_r <= 16'h2001;
      fr_r <= 16'h0002;
    end else if (wr_en) begin
      if (addr == 5'h00) pc_r <= wr_data;
      if (addr == 5'h01) rg_r <= wr_data;
      if (addr == 5'h04) fr_r <= wr_data;
    end
  end
  property p_pc_top;
    rd_en && addr == 5'h00 |=> rd_data[15:14] == 2'b00;
  endproperty
  a_pc_top: assert property (p_pc_top) else $error("pin top bits set");
  property p_rg_rd;
    rd_en && addr == 5'h01 |=> rd_data[13] == $past(rg_r[13]);
  endproperty
  a_rg_rd: assert property (p_rg_rd) else $error("source bit lost");
  property p_wlen;
    word_bits inside {6'h00, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18, 6'h20};
  endproperty
  a_wlen: assert property (p_wlen) else $error("odd word length");
  property p_wl_err;
    word_bits == 6'h00 [*2] |-> cfg_error;
  endproperty
  a_wl_err: assert property (p_wl_err) else $error("bad length ok");
  property p_rsv;
    (!pc_r[7] && !rg_r[13]) [*2] |-> cfg_error;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved source ok");
  property p_rx_off;
    pc_r[7] && !rg_r[13] |-> !rx_drive.clk_oe;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("rx pin driven");
  property p_tx_off;
    pc_r[7] && rg_r[13] |-> !tx_drive.clk_oe;
  endproperty
  a_tx_off: assert property (p_tx_off) else $error("tx pin driven");
  property p_tx_gen;
    pc_r[7] && !rg_r[13] && pc_r[9] && !fr_r[4] |-> tx_drive.clk_oe;
  endproperty
  a_tx_gen: assert property (p_tx_gen) else $error("tx not driven");
  property p_rx_gen;
    pc_r[8] && !pc_r[7] && !fr_r[4] |-> rx_drive.clk_oe;
  endproperty
  a_rx_gen: assert property (p_rx_gen) else $error("rx not driven");
  property p_spi;
    fr_r[4] && !pc_r[7]
      |-> tx_drive.clk_oe == fr_r[5] && rx_drive.clk_oe == fr_r[5];
  endproperty
  a_spi: assert property (p_spi) else $error("spi roles differ");
  c_tick: cover property (rate_clock_tick);
  c_err: cover property (cfg_error);
  c_pin: cover property (pc_r[7] && !rg_r[13] && pc_r[9]);
endmodule
bind mscp_port mscp_chk u_chk (.clock(clock), .reset(reset), .addr(addr),
  .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
  .tx_drive(tx_drive), .rx_drive(rx_drive), .word_bits(word_bits),
  .rate_clock_tick(rate_clock_tick), .cfg_error(cfg_error));
`default_nettype wire

/* tb/mscp_peer.sv */
// far-side serial device: clock, frame and data toward the port
`timescale 1ns/1ns
`default_nettype none
module mscp_peer
  import mscp_pkg::*;
(
  input wire logic run, // frames flow while high
  input wire logic [10:0] frame_len, // bits per frame
  output var mscp_pins_t pins // levels toward the port
);
  int bit_n;
  logic idle;
  // 80 ns clock that runs on through frame boundaries and stands low while run is low
  initial begin
    pins = '0;
    bit_n = 0;
    idle = 1'b0;
    forever begin
      #40;
      if (run) begin
        idle = 1'b0;
        pins.clk = ~pins.clk;
        if (!pins.clk) begin
          pins.frame = (bit_n == 0);
          pins.data = 1'($urandom);
          bit_n = (bit_n + 1) % int'(frame_len);
        end
      end else begin
        pins.clk = 1'b0;
        pins.frame = 1'b0;
        // released data line flips once so a stale sample shows up
        if (!idle)
          pins.data = ~pins.data;
        idle = 1'b1;
        bit_n = 0;
      end
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// testbench: register bus, clock selection and channel selection checks
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import mscp_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [15:0] wr_data = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [15:0] rd_data;
  logic run = 1'b0;
  logic [10:0] flen = 11'h008;
  mscp_pins_t pins;
  mscp_drive_t tx_drive;
  mscp_drive_t rx_drive;
  logic tx_act, rx_act, tick, cfg_error;
  logic [6:0] tx_idx, rx_idx;
  logic [5:0] word_bits;
  logic [15:0] ch [12];
  logic [15:0] v;
  int miscompares = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  always #4 clock = ~clock;
  mscp_peer peer (.run(run), .frame_len(flen), .pins(pins));
  mscp_port uut (.clock(clock), .reset(reset), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .tx_pins_in(pins), .rx_pins_in(pins), .tx_drive(tx_drive),
    .rx_drive(rx_drive), .tx_data_out(), .tx_data_oe(),
    .tx_chan_active(tx_act), .rx_chan_active(rx_act),
    .tx_chan_idx(tx_idx), .rx_chan_idx(rx_idx), .word_bits(word_bits),
    .rate_clock_tick(tick), .cfg_error(cfg_error));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard: the whole sequence needs well under this
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      end_sim;
    end
  end
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, g);
      miscompares++;
    end
  endtask
  // bus tasks are entered just after a rising edge
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clock);
    wr_en <= 1'b0;
    // idle cycle so a following write never re-raises the strobe at once
    @(posedge clock);
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd_en <= 1'b0;
    @(negedge clock);
    d = rd_data;
    @(posedge clock);
  endtask
  function automatic logic [5:0] wl(input int c);
    case (c)
      0: return 6'h08;
      1: return 6'h0c;
      2: return 6'h10;
      3: return 6'h14;
      4: return 6'h18;
      5: return 6'h20;
      default: return 6'h00;
    endcase
  endfunction
  // channels above 95 are always on in wide mode, legacy stops at 31
  function automatic logic act(input logic wide, input int b,
                               input logic [6:0] i);
    if (wide && i >= 7'h60) return 1'b1;
    if (!wide && i >= 7'h20) return 1'b0;
    return ch[b + int'(i[6:4])][i[3:0]];
  endfunction
  task automatic mc_run(input logic wide);
    logic [6:0] pr, pt;
    wr(5'h02, {6'h00, wide, 9'h001});
    wr(5'h03, {6'h00, wide, 9'h001});
    for (int i = 0; i < 12; i++) begin
      ch[i] = 16'($urandom);
      wr(5'(16 + i), ch[i]);
    end
    pr = rx_idx;
    pt = tx_idx;
    repeat (10400) begin
      @(negedge clock);
      if (rx_idx === pr) chk("rx_act", 16'(act(wide, 0, rx_idx)), 16'(rx_act));
      if (tx_idx === pt) chk("tx_act", 16'(act(wide, 6, tx_idx)), 16'(tx_act));
      pr = rx_idx;
      pt = tx_idx;
    end
    @(posedge clock);
  endtask
  logic [15:0] rst_v [5] = '{16'h0000, 16'h2001, 16'h0000, 16'h0000,
                             16'h0002};
  initial begin
    void'($urandom(1030));
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    for (int i = 0; i < 5; i++) begin
      rd(5'(i), v);
      // rx data state bit of pin control mirrors the idle data line
      chk("reg_reset", rst_v[i] | ((i == 0) ? 16'(pins.data) << 4 : 16'h0000), v);
    end
    rd(5'h10, v);
    chk("ch_reset", 16'h0000, v);
    wr(5'h00, 16'hffff);
    rd(5'h00, v);
    chk("pin_ctrl", 16'h3faf | (16'(pins.data) << 4), v);
    wr(5'h1f, 16'(($urandom)));
    rd(5'h1f, v);
    chk("unmapped", 16'h0000, v);
    wr(5'h00, 16'h0000);
    // every word length code, legal and not
    for (int c = 0; c < 8; c++) begin
      wr(5'h04, 16'(c));
      rd(5'h04, v);
      chk("word_bits", 16'(wl(c)), 16'(word_bits));
      chk("len_err", 16'(c > 5), 16'(cfg_error));
    end
    wr(5'h04, 16'h0002);
    // all four source selections, both clock pins set to drive
    for (int s = 0; s < 4; s++) begin
      wr(5'h00, 16'h0300 | 16'((s >> 1) << 7));
      wr(5'h01, 16'h0001 | 16'((s & 1) << 13));
      rd(5'h01, v);
      chk("src_bit", 16'(s & 1), 16'(v[13]));
      rd(5'h05, v);
      chk("src", 16'(s), 16'(v[6:5]));
      chk("rsv_err", 16'(s == 0), 16'(cfg_error));
      chk("rx_oe", 16'(s != 2), 16'(rx_drive.clk_oe));
      chk("tx_oe", 16'(s != 3), 16'(tx_drive.clk_oe));
    end
    // rx pin as rate input: still pin gives no ticks, running pin does
    wr(5'h00, 16'h0080);
    wr(5'h01, 16'h0001);
    n = 0;
    repeat (300) begin
      @(negedge clock);
      n += int'(tick);
    end
    chk("ticks_idle", 16'h0000, 16'(n));
    @(posedge clock);
    run <= 1'b1;
    n = 0;
    repeat (2000) begin
      @(negedge clock);
      n += int'(tick);
    end
    chk("ticks_run", 16'h0001, 16'(n != 0));
    @(posedge clock);
    run <= 1'b0;
    wr(5'h00, 16'h0000);
    wr(5'h01, 16'h2001);
    wr(5'h04, 16'h0030);
    rd(5'h04, v);
    chk("spi_mst", 16'h0003, 16'({tx_drive.clk_oe, rx_drive.clk_oe}));
    wr(5'h04, 16'h0010);
    rd(5'h04, v);
    chk("spi_slv", 16'h0000, 16'({tx_drive.clk_oe, rx_drive.clk_oe}));
    // clock stop: one word per frame keeps the channel at zero
    flen <= 11'h008;
    run <= 1'b1;
    repeat (300) @(posedge clock);
    repeat (2000) begin
      @(negedge clock);
      chk("stop_idx", 16'h0000, 16'(rx_idx));
    end
    @(posedge clock);
    wr(5'h04, 16'h0000);
    flen <= 11'h400;
    mc_run(1'b0);
    mc_run(1'b1);
    end_sim;
  end
endmodule
`default_nettype wire
